// File: lcd_timing_pkg.sv
package lcd_timing_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets on the plain register port.
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] PHASE_OFS  = 8'h01;
  localparam logic [7:0] SEL_OFS    = 8'h02;  // Eight select registers.
  localparam logic [7:0] SEL_LAST   = 8'h09;
  localparam logic [7:0] STATUS_OFS = 8'h0A;
  localparam logic [7:0] PIX_OFS    = 8'h40;  // Sixty-four pixel registers.
  localparam logic [7:0] PIX_LAST   = 8'h7F;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int CTRL_EN_BIT   = 7;
  localparam int CTRL_SLP_BIT  = 6;
  localparam int CTRL_MUX_LSB  = 2;
  localparam int CTRL_CS_LSB   = 0;
  localparam int PHASE_WFT_BIT = 7;
  localparam int PHASE_LP_LSB  = 0;
  localparam int STAT_RUN_BIT  = 7;
  localparam int STAT_POL_BIT  = 6;
  localparam int STAT_COM_LSB  = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] PHASE_RST = 8'h00;
  localparam logic [7:0] SEL_RST   = 8'h00;
  localparam logic [7:0] PIX_RST   = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Common count codes and the per-code frame factor.
  localparam logic [2:0] MUX_STATIC = 3'h0;
  localparam logic [2:0] MUX_HALF   = 3'h1;
  localparam logic [1:0] K_STATIC_M1 = 2'h3;  // Factor four, minus one.
  localparam logic [1:0] K_HALF_M1   = 2'h1;  // Factor two, minus one.
  localparam logic [1:0] K_MULTI_M1  = 2'h0;  // Factor one, minus one.

  // Clock select code that feeds no source at all.
  localparam logic [1:0] CS_NONE = 2'h3;

endpackage

// File: lcd_clock_select.sv
`timescale 1ns/1ns
module lcd_clock_select (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [2:0] src_tick,
  input  wire logic [1:0] clk_sel,
  input  wire logic       run,
  output logic            tick
);

  typedef struct packed {
    logic tick;
  } sel_state_t;

  sel_state_t st_r;
  sel_state_t st_nxt;

  // Pick one source tick; the spare code is silent so software sees a halt.
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (run && clk_sel != lcd_timing_pkg::CS_NONE) begin
      st_nxt.tick = src_tick[clk_sel]; // RULE3
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;

endmodule // lcd_clock_select

// File: lcd_frame_divider.sv
`timescale 1ns/1ns
module lcd_frame_divider (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       run,
  input  wire logic       tick,
  input  wire logic [2:0] mux,
  input  wire logic [3:0] prescale,
  input  wire logic       wave_b,
  output logic [2:0]      com_idx,
  output logic            pol,
  output logic            frame
);

  typedef struct packed {
    logic [3:0] pre;
    logic [1:0] sub;
    logic [2:0] com;
    logic       pol;
    logic       frame;
  } div_state_t;

  div_state_t st_r;
  div_state_t st_nxt;
  logic [1:0] k_m1;

  // Frame factor: four ticks per slot static, two half, one otherwise.
  always_comb begin
    unique case (mux)
      lcd_timing_pkg::MUX_STATIC: k_m1 = lcd_timing_pkg::K_STATIC_M1; // RULE12
      lcd_timing_pkg::MUX_HALF:   k_m1 = lcd_timing_pkg::K_HALF_M1;   // RULE12
      default:                    k_m1 = lcd_timing_pkg::K_MULTI_M1;  // RULE12
    endcase
  end

  // Prescaler, then slot counter, then common index; one frame spans
  // factor * commons * (prescale + 1) source ticks.
  always_comb begin
    st_nxt = st_r;
    st_nxt.frame = 1'b0;
    if (!run) begin
      st_nxt = '0;
    end else if (tick) begin
      if (st_r.pre >= prescale) begin // RULE6
        st_nxt.pre = 4'h0;
        if (st_r.sub >= k_m1) begin
          st_nxt.sub = 2'h0;
          if (st_r.com >= mux) begin // RULE4
            st_nxt.com = 3'h0;
            st_nxt.frame = 1'b1; // RULE12
          end else begin
            st_nxt.com = st_r.com + 3'h1;
          end
          // Type A inverts every slot, Type B only at frame end.
          if (!wave_b || st_r.com >= mux) begin
            st_nxt.pol = ~st_r.pol; // RULE5
          end
        end else begin
          st_nxt.sub = st_r.sub + 2'h1;
        end
      end else begin
        st_nxt.pre = st_r.pre + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign com_idx = st_r.com;
  assign pol     = st_r.pol;
  assign frame   = st_r.frame;

endmodule // lcd_frame_divider

// File: lcd_timing_control.sv
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
// Contract
// RULE1: Control bit 7 set runs the LCD block; cleared stops it.
// RULE2: With control bit 6 clear, the panel keeps running during sleep.
// RULE3: Two-bit clock select field chooses the LCD timing clock source.
// RULE4: Common count field sets active commons; two or three bits wide.
// RULE5: Phase waveform bit 0 gives Type-A, 1 gives Type-B.
// RULE6: Four-bit prescale field divides the LCD clock, setting frame rate.
// RULE7: A set select bit makes its pin a segment driver output.
// RULE8: A cleared select bit returns its pin to general-purpose I/O.
// RULE9: Eight select registers, bit b of register k is segment 8k+b.
// RULE10: Up to 64 segments, static or multiplexed, four or eight commons.
// RULE11: Software matches common count to glass and picks a sane prescaler.
// RULE12: Frame equals source over factor times commons times prescale+1.
// RULE13: Pixel bit 0 shows clear, 1 shows dark, per segment and common.
// RULE14: While stopped, every driven segment and common sits at one level.
module lcd_timing_control #(
  parameter int NUM_SEG  = 64,
  parameter int NUM_COM  = 8,
  parameter int COM_BITS = 3
) (
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic [7:0]         addr,
  input  wire logic [7:0]         wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  output logic      [7:0]         rdata,
  input  wire logic               cpu_sleep,
  input  wire logic [2:0]         src_tick,
  input  wire logic [NUM_SEG-1:0] gpio_out,
  input  wire logic [NUM_SEG-1:0] gpio_oe,
  output logic      [NUM_SEG-1:0] pin_out,
  output logic      [NUM_SEG-1:0] pin_oe,
  output logic      [NUM_COM-1:0] com_out,
  output logic      [NUM_COM-1:0] com_active,
  output logic                    frame_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  localparam int NUM_SEL = NUM_SEG / 8; // RULE9
  localparam int NUM_PIX = NUM_SEL * NUM_COM;

  typedef struct packed {
    logic [7:0]                      ctrl;
    logic [7:0]                      phase;
    logic [NUM_SEL-1:0][7:0]         sel;
    logic [NUM_PIX-1:0][7:0]         pix;
    logic [7:0]                      rdata;
    logic [NUM_SEG-1:0]              seg;
    logic [NUM_COM-1:0]              com;
    logic [NUM_COM-1:0]              act;
  } top_state_t;

  top_state_t         st_r;
  top_state_t         st_nxt;
  logic               run;
  logic               tick;
  logic [2:0]         mux;
  logic [2:0]         com_idx;
  logic               pol;
  logic               frame;
  logic [NUM_SEG-1:0] seg_dark;
  logic [NUM_SEG-1:0] sel_flat;

  ////////////////////////////////////////////////////////////////////////////
  // Control decode.

  // The panel runs when enabled, and through sleep only if sleep stop is
  // clear; a sleeping core with sleep stop set parks the drive like disable.
  assign run = st_r.ctrl[lcd_timing_pkg::CTRL_EN_BIT] // RULE1
             && !(cpu_sleep
                  && st_r.ctrl[lcd_timing_pkg::CTRL_SLP_BIT]); // RULE2

  // Four-common parts see only the low two bits of the count field.
  generate
    if (COM_BITS == 2) begin : g_mux2
      assign mux = {1'b0,
        st_r.ctrl[lcd_timing_pkg::CTRL_MUX_LSB +: 2]}; // RULE4
    end else begin : g_mux3
      assign mux = st_r.ctrl[lcd_timing_pkg::CTRL_MUX_LSB +: 3]; // RULE4
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Clock source and frame timing.

  lcd_clock_select u_clock_select (
    .clk      (clk),
    .rst_b    (rst_b),
    .src_tick (src_tick),
    .clk_sel  (st_r.ctrl[lcd_timing_pkg::CTRL_CS_LSB +: 2]),
    .run      (run),
    .tick     (tick)
  );

  lcd_frame_divider u_frame_divider (
    .clk      (clk),
    .rst_b    (rst_b),
    .run      (run),
    .tick     (tick),
    .mux      (mux),
    .prescale (st_r.phase[lcd_timing_pkg::PHASE_LP_LSB +: 4]),
    .wave_b   (st_r.phase[lcd_timing_pkg::PHASE_WFT_BIT]),
    .com_idx  (com_idx),
    .pol      (pol),
    .frame    (frame)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Per-segment pixel lookup and pin ownership.

  // Each segment reads the byte for the active common; the byte index is
  // the common times the register count plus the segment group.
  generate
    for (genvar s = 0; s < NUM_SEG; s++) begin : g_seg
      assign seg_dark[s] =
        st_r.pix[(32'(com_idx) * NUM_SEL) + (s / 8)][s % 8]; // RULE13
      assign sel_flat[s] = st_r.sel[s / 8][s % 8]; // RULE9
      // A selected pin is a driver output; otherwise GPIO owns it fully.
      assign pin_out[s] = sel_flat[s] ? st_r.seg[s] : gpio_out[s]; // RULE7
      assign pin_oe[s]  = sel_flat[s] ? 1'b1 : gpio_oe[s]; // RULE8
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Register port and drive levels.

  always_comb begin
    logic [5:0] pidx;
    logic [2:0] sidx;
    pidx = 6'h00;
    sidx = 3'h0;
    st_nxt = st_r;

    // Writes; unmapped offsets are dropped silently.
    if (wr) begin
      if (addr == lcd_timing_pkg::CTRL_OFS) begin
        st_nxt.ctrl = wdata; // RULE1
      end else if (addr == lcd_timing_pkg::PHASE_OFS) begin
        st_nxt.phase = wdata; // RULE5
      end else if (addr >= lcd_timing_pkg::SEL_OFS
                   && addr <= lcd_timing_pkg::SEL_LAST) begin
        sidx = 3'(addr - lcd_timing_pkg::SEL_OFS);
        st_nxt.sel[sidx] = wdata; // RULE9
      end else if (addr >= lcd_timing_pkg::PIX_OFS
                   && addr <= lcd_timing_pkg::PIX_LAST) begin
        pidx = 6'(addr - lcd_timing_pkg::PIX_OFS);
        st_nxt.pix[pidx] = wdata; // RULE13
      end
    end

    // Read data stands for exactly the cycle after the strobe.
    st_nxt.rdata = 8'h00;
    if (rd) begin
      if (addr == lcd_timing_pkg::CTRL_OFS) begin
        st_nxt.rdata = st_r.ctrl;
      end else if (addr == lcd_timing_pkg::PHASE_OFS) begin
        st_nxt.rdata = st_r.phase;
      end else if (addr >= lcd_timing_pkg::SEL_OFS
                   && addr <= lcd_timing_pkg::SEL_LAST) begin
        sidx = 3'(addr - lcd_timing_pkg::SEL_OFS);
        st_nxt.rdata = st_r.sel[sidx];
      end else if (addr == lcd_timing_pkg::STATUS_OFS) begin
        st_nxt.rdata[lcd_timing_pkg::STAT_RUN_BIT] = run;
        st_nxt.rdata[lcd_timing_pkg::STAT_POL_BIT] = pol;
        st_nxt.rdata[lcd_timing_pkg::STAT_COM_LSB +: 3] = com_idx;
      end else if (addr >= lcd_timing_pkg::PIX_OFS
                   && addr <= lcd_timing_pkg::PIX_LAST) begin
        pidx = 6'(addr - lcd_timing_pkg::PIX_OFS);
        st_nxt.rdata = st_r.pix[pidx];
      end
    end

    // Segment level: a dark pixel drives against the common phase, a clear
    // pixel follows it, so the pixel sees either full swing or none.
    // Bias levels for the idle commons come from the analog ladder; this
    // block only marks which common is selected.
    if (run) begin
      for (int s = 0; s < NUM_SEG; s++) begin
        st_nxt.seg[s] = seg_dark[s] ^ pol; // RULE13
      end
      // A count shrunk mid-frame leaves the index past the new last common
      // for one slot; mark common zero then, so the drive never looks idle
      // while the block runs.
      for (int c = 0; c < NUM_COM; c++) begin
        st_nxt.act[c] = (3'(c) == ((com_idx <= mux) ? com_idx : 3'h0)); // RULE4
        st_nxt.com[c] = pol; // RULE10
      end
    end else begin
      // Everything flat at one level so no DC builds across the glass.
      st_nxt.seg = '0; // RULE14
      st_nxt.com = '0; // RULE14
      st_nxt.act = '0; // RULE14
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r.ctrl  <= lcd_timing_pkg::CTRL_RST;
      st_r.phase <= lcd_timing_pkg::PHASE_RST;
      st_r.sel   <= {NUM_SEL{lcd_timing_pkg::SEL_RST}};
      st_r.pix   <= {NUM_PIX{lcd_timing_pkg::PIX_RST}};
      st_r.rdata <= 8'h00;
      st_r.seg   <= '0;
      st_r.com   <= '0;
      st_r.act   <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign rdata       = st_r.rdata;
  assign com_out     = st_r.com;
  assign com_active  = st_r.act;
  assign frame_pulse = frame; // RULE12

endmodule // lcd_timing_control

// File: lcd_timing_control_chk.sv
`timescale 1ns/1ns
module lcd_timing_control_chk #(
  parameter int NUM_SEG = 64,
  parameter int NUM_COM = 8
) (
  input wire logic               clk,
  input wire logic               rst_b,
  input wire logic [7:0]         addr,
  input wire logic [7:0]         wdata,
  input wire logic               wr,
  input wire logic               rd,
  input wire logic [7:0]         rdata,
  input wire logic               cpu_sleep,
  input wire logic [2:0]         src_tick,
  input wire logic [NUM_SEG-1:0] gpio_out,
  input wire logic [NUM_SEG-1:0] gpio_oe,
  input wire logic [NUM_SEG-1:0] pin_out,
  input wire logic [NUM_SEG-1:0] pin_oe,
  input wire logic [NUM_COM-1:0] com_out,
  input wire logic [NUM_COM-1:0] com_active,
  input wire logic               frame_pulse
);
  ////////////////////////////////////////////////////////////////////////////
  // One clock domain, so clocking and disable are shared.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Idle pins mirror the GPIO wish; with no common active, every pin without GPIO enable rests.
  a_read_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
  a_gpio_pass: assert property (((pin_out ^ gpio_out) & ~pin_oe) == '0)
    else $error("released pin not following gpio");
  a_oe_keep: assert property ((gpio_oe & ~pin_oe) == '0)
    else $error("pin enable lost");
  a_com_onehot: assert property ($onehot0(com_active))
    else $error("more than one common active");
  a_stop_com: assert property (com_active == '0 |-> com_out == '0)
    else $error("common level while stopped");
  a_stop_seg: assert property (com_active == '0 |->
    (pin_out & pin_oe & ~gpio_oe) == '0)
    else $error("segment level while stopped");
  a_frame_gap: assert property (frame_pulse |=> !frame_pulse [*2])
    else $error("frames too close");
  // Without ticks or writes the drive cannot move once the pipe drains.
  a_quiet_hold: assert property ((src_tick == 3'h0 && !wr &&
    $stable(cpu_sleep)) [*4] |-> $stable(com_active) && $stable(com_out))
    else $error("drive moved without ticks");
  c_frame: cover property (frame_pulse);
  c_read: cover property (rd ##1 rdata != 8'h00);
  c_multi: cover property (com_active[1]);
endmodule // lcd_timing_control_chk

bind lcd_timing_control lcd_timing_control_chk #(
  .NUM_SEG(NUM_SEG), .NUM_COM(NUM_COM)) u_lcd_timing_control_chk (
  .clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata, .cpu_sleep, .src_tick,
  .gpio_out, .gpio_oe, .pin_out, .pin_oe, .com_out, .com_active,
  .frame_pulse);

// File: lcd_glass.sv
`timescale 1ns/1ns
module lcd_glass #(
  parameter int NUM_SEG = 64,
  parameter int NUM_COM = 8
) (
  input wire logic                            clk,
  input wire logic [NUM_SEG-1:0]              seg,
  input wire logic [NUM_SEG-1:0]              seg_oe,
  input wire logic [NUM_COM-1:0]              com,
  input wire logic [NUM_COM-1:0]              com_on,
  output logic     [NUM_COM-1:0][NUM_SEG-1:0] dark
);
  ////////////////////////////////////////////////////////////////////////////
  // A pixel darkens while its segment differs from its active common.
  // Released pins float, so they never darken a pixel.
  always_ff @(posedge clk) begin
    for (int c = 0; c < NUM_COM; c++) begin
      if (com_on[c]) begin
        dark[c] <= (seg ^ {NUM_SEG{com[c]}}) & seg_oe;
      end
    end
  end
endmodule // lcd_glass

// File: lcd_timing_control_test.sv
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("Error %0t: got %h want %h", $time, g, e); end end
module lcd_timing_control_test;
  logic            clk;
  logic            rst_b;
  logic [7:0]      addr;
  logic [7:0]      wdata;
  logic            wr;
  logic            rd;
  logic [7:0]      rdata;
  logic            cpu_sleep;
  logic [2:0]      src_tick;
  logic [63:0]     gpio_out;
  logic [63:0]     gpio_oe;
  logic [63:0]     pin_out;
  logic [63:0]     pin_oe;
  logic [7:0]      com_out;
  logic [7:0]      com_active;
  logic            frame_pulse;
  logic [7:0][63:0] dark;
  int              fails;
  int              check_count;
  ////////////////////////////////////////////////////////////////////////////
  lcd_timing_control u_lcd_timing_control (.clk(clk), .rst_b(rst_b),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .cpu_sleep(cpu_sleep), .src_tick(src_tick), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .pin_out(pin_out), .pin_oe(pin_oe),
    .com_out(com_out), .com_active(com_active), .frame_pulse(frame_pulse));
  lcd_glass u_lcd_glass (.clk(clk), .seg(pin_out), .seg_oe(pin_oe),
    .com(com_out), .com_on(com_active), .dark(dark));

  // The clock toggles every 10 ns, a period of 20 ns.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Register port cycles; read data is taken in the cycle after the strobe.
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Counts cycles up to the next frame pulse; a hang ends the run.
  task automatic pulse_wait(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (frame_pulse !== 1'b1 && n < 500);
    if (n >= 500) begin
      fails++;
      finish_test();
    end
  endtask
  task automatic no_frames();
    logic seen;
    seen = 1'b0;
    repeat (40) begin
      @(posedge clk);
      #1;
      seen = seen | frame_pulse;
    end
    `CHK(seen, 1'b0)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] v;
    for (int a = 0; a <= 10; a++) begin
      reg_rd(a[7:0], v);
      `CHK(v, 8'h00)
    end
    for (int a = 0; a <= 9; a++) begin
      reg_wr(a[7:0], 8'h30 + a[7:0]);
      reg_rd(a[7:0], v);
      `CHK(v, 8'h30 + a[7:0])
      reg_wr(a[7:0], 8'h00);
    end
    reg_wr(lcd_timing_pkg::STATUS_OFS, 8'hFF);
    reg_rd(lcd_timing_pkg::STATUS_OFS, v);
    `CHK(v, 8'h00)
    reg_wr(8'h20, 8'hFF);
    reg_rd(8'h20, v);
    `CHK(v, 8'h00)
    $display("t_regs done");
  endtask

  // Selected pins leave GPIO; the mask spans both ends of the range.
  task automatic t_pins();
    gpio_out <= 64'hA5A5_A5A5_5A5A_5A5A;
    reg_wr(lcd_timing_pkg::SEL_OFS, 8'h81);
    reg_wr(lcd_timing_pkg::SEL_LAST, 8'h01);
    cycles(1);
    `CHK(pin_oe, 64'h0100_0000_0000_0081)
    `CHK(pin_out & 64'hFEFF_FFFF_FFFF_FF7E, gpio_out & 64'hFEFF_FFFF_FFFF_FF7E)
    reg_wr(lcd_timing_pkg::SEL_LAST, 8'h00);
    reg_wr(lcd_timing_pkg::SEL_OFS, 8'hFF);
    cycles(1);
    `CHK(pin_oe, 64'h0000_0000_0000_00FF)
    $display("t_pins done");
  endtask

  // Every common count code with a changing prescale, one tick a cycle.
  task automatic t_frame();
    int n;
    int k;
    src_tick <= 3'b010;
    reg_wr(lcd_timing_pkg::CTRL_OFS, 8'h80);
    no_frames();
    for (int m = 0; m < 8; m++) begin
      k = (m == 0) ? 4 : (m == 1) ? 2 : 1;
      reg_wr(lcd_timing_pkg::PHASE_OFS, {6'h00, m[1:0]});
      reg_wr(lcd_timing_pkg::CTRL_OFS, {3'h4, m[2:0], 2'h1});
      pulse_wait(n);
      pulse_wait(n);
      pulse_wait(n);
      `CHK(n, k * (m + 1) * (m % 4 + 1))
      `CHK(com_active >> (m + 1), 8'h00)
    end
    src_tick <= 3'b100;
    reg_wr(lcd_timing_pkg::PHASE_OFS, 8'h00);
    reg_wr(lcd_timing_pkg::CTRL_OFS, 8'h82);
    pulse_wait(n);
    pulse_wait(n);
    `CHK(n, 4)
    src_tick <= 3'b111;
    reg_wr(lcd_timing_pkg::CTRL_OFS, 8'h83);
    no_frames();
    $display("t_frame done");
  endtask

  // Two commons: Type-A flips each slot, Type-B once a frame.
  task automatic t_wave();
    int n;
    int t;
    logic p;
    reg_wr(lcd_timing_pkg::CTRL_OFS, 8'h85);
    for (int w = 0; w < 2; w++) begin
      reg_wr(lcd_timing_pkg::PHASE_OFS, {w[0], 7'h00});
      pulse_wait(n);
      t = 0;
      p = com_out[0];
      repeat (16) begin
        @(posedge clk);
        #1;
        if (com_out[0] !== p) t++;
        p = com_out[0];
      end
      `CHK(t, (w == 1) ? 4 : 8)
    end
    $display("t_wave done");
  endtask

  task automatic t_pixel();
    logic [7:0] v;
    reg_wr(lcd_timing_pkg::PIX_OFS, 8'h5A);
    reg_wr(lcd_timing_pkg::PHASE_OFS, 8'h00);
    reg_wr(lcd_timing_pkg::CTRL_OFS, 8'h81);
    cycles(20);
    `CHK(dark[0][7:0], 8'h5A)
    reg_rd(lcd_timing_pkg::PIX_OFS, v);
    `CHK(v, 8'h5A)
    $display("t_pixel done");
  endtask

  // Sleep stop halts the panel; with it clear the panel keeps going.
  task automatic t_sleep();
    logic [7:0] v;
    int n;
    cpu_sleep <= 1'b1;
    reg_wr(lcd_timing_pkg::CTRL_OFS, 8'hC1);
    cycles(6);
    `CHK(com_active, 8'h00)
    reg_wr(lcd_timing_pkg::CTRL_OFS, 8'h81);
    reg_rd(lcd_timing_pkg::STATUS_OFS, v);
    `CHK(v[7], 1'b1)
    pulse_wait(n);
    pulse_wait(n);
    `CHK(n, 4)
    cpu_sleep <= 1'b0;
    reg_wr(lcd_timing_pkg::CTRL_OFS, 8'h01);
    cycles(4);
    `CHK(com_active, 8'h00)
    `CHK(pin_out[7:0], 8'h00)
    `CHK(pin_oe[7:0], 8'hFF)
    $display("t_sleep done");
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Reset for eight cycles, then run each scenario in turn.
  initial begin
    fails = 0;
    check_count = 0;
    rst_b = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    cpu_sleep = 1'b0;
    src_tick = 3'h0;
    gpio_out = 64'h0;
    gpio_oe = 64'h0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_pins();
    t_frame();
    t_wave();
    t_pixel();
    t_sleep();
    finish_test();
  end
endmodule // lcd_timing_control_test
